// ### logic/vfd_pkg.sv
package vfd_pkg;

  // word and link layout
  localparam int WORD_BITS  = 12;
  localparam int FIFO_DEPTH = 16;
  localparam int PIN_COUNT  = 4;
  localparam int PIN_CLK    = 0;
  localparam int PIN_DIN    = 1;
  localparam int PIN_LOAD   = 2;
  localparam int PIN_BLANK  = 3;

  // timing, in ns and in clock cycles at 100 MHz
  localparam int SYS_PERIOD_NS  = 10;
  localparam int SCLK_HALF_NS   = 100;
  localparam int LOAD_HOLD_NS   = 100;
  localparam int LOAD_HIGH_NS   = 55;
  localparam int COUNT_W        = 8;
  localparam int SCLK_HALF_INT  =
    (SCLK_HALF_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int LOAD_HOLD_INT  =
    (LOAD_HOLD_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int LOAD_HIGH_INT  =
    (LOAD_HIGH_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam logic [COUNT_W-1:0] SCLK_HALF_CYCLES =
    COUNT_W'(SCLK_HALF_INT);
  localparam logic [COUNT_W-1:0] LOAD_HOLD_CYCLES =
    COUNT_W'(LOAD_HOLD_INT);
  localparam logic [COUNT_W-1:0] LOAD_HIGH_CYCLES =
    COUNT_W'(LOAD_HIGH_INT);

  // values after reset
  localparam logic [WORD_BITS-1:0] WORD_RESET = 12'h000;

  typedef enum logic [2:0] {
    host_idle,
    host_clk_low,
    host_clk_high,
    host_load_wait,
    host_load_high
  } host_state_e;

endpackage

// ### logic/vfd_link.sv
`timescale 1ns/1ps
interface vfd_link;
  logic serial_clock;
  logic serial_in;
  logic load;
  logic blank;
  logic serial_out;

  modport device (
    input  serial_clock,
    input  serial_in,
    input  load,
    input  blank,
    output serial_out
  );

  modport host (
    output serial_clock,
    output serial_in,
    output load,
    output blank
  );
endinterface

// ### logic/vfd_driver_end.sv
// Behaviour
// - shift one place per serial clock rise
// - host sends highest word bit first
// - latch follows shift register while load high
// - load fall freezes latch while load low
// - blank forces outputs low, latch kept
// - blank low, outputs show latch bits
// - shifting and latching ignore blank level
// - reset clears registers, outputs, serial out
// - serial out shows last stage, clock fall
// - host holds serial data around clock rise
// - host: clock low, twelve bits, load fall
// - load level free during shifting
// - every clock rise shifts regardless of load
// - each chained device gets own load
// - serial out feeds next device input
`timescale 1ns/1ps
module vfd_driver_end (
  input  wire logic                           clock,
  input  wire logic                           resetn,
  vfd_link.device                             link,
  output logic [vfd_pkg::WORD_BITS-1:0]       driver_outputs
);

  typedef struct packed {
    logic [vfd_pkg::PIN_COUNT-1:0] sync_a;
    logic [vfd_pkg::PIN_COUNT-1:0] sync_b;
    logic                          clk_seen;
    logic [vfd_pkg::WORD_BITS-1:0] shift;
    logic [vfd_pkg::WORD_BITS-1:0] latch;
    logic                          serial_out;
    logic [vfd_pkg::WORD_BITS-1:0] outputs;
  } driver_state_s;

  driver_state_s cur;
  driver_state_s next_cur;
  logic          clk_s;
  logic          din_s;
  logic          load_s;
  logic          blank_s;
  logic          clk_rise;
  logic          clk_fall;
  logic [vfd_pkg::WORD_BITS-1:0] next_shift;
  logic [vfd_pkg::WORD_BITS-1:0] next_latch;
  logic [vfd_pkg::WORD_BITS-1:0] next_outputs;

  // only the second synchroniser stage is looked at
  assign clk_s   = cur.sync_b[vfd_pkg::PIN_CLK];
  assign din_s   = cur.sync_b[vfd_pkg::PIN_DIN];
  assign load_s  = cur.sync_b[vfd_pkg::PIN_LOAD];
  assign blank_s = cur.sync_b[vfd_pkg::PIN_BLANK];
  assign clk_rise = clk_s & ~cur.clk_seen;
  assign clk_fall = ~clk_s & cur.clk_seen;

  always_comb begin
    next_shift = cur.shift;
    if (clk_rise) begin
      next_shift = {cur.shift[vfd_pkg::WORD_BITS-2:0], din_s};
    end
  end

  // a latch that is open tracks the shift register; once load drops the
  // last value seen while open stays put
  always_comb begin
    if (load_s) begin
      next_latch = next_shift;
    end else begin
      next_latch = cur.latch;
    end
  end

  generate
    for (genvar k = 0; k < vfd_pkg::WORD_BITS; k++) begin : g_out
      // blank gates only the driven pins, never the latch
      assign next_outputs[k] = next_latch[k] & ~blank_s;
    end
  endgenerate

  always_comb begin
    next_cur = cur;
    next_cur.sync_a = {link.blank, link.load, link.serial_in,
                       link.serial_clock};
    next_cur.sync_b = cur.sync_a;
    next_cur.clk_seen = clk_s;
    next_cur.shift = next_shift;
    next_cur.latch = next_latch;
    next_cur.outputs = next_outputs;
    if (clk_fall) begin
      next_cur.serial_out = cur.shift[vfd_pkg::WORD_BITS-1];
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign driver_outputs  = cur.outputs;
  assign link.serial_out = cur.serial_out;

endmodule // vfd_driver_end

// ### logic/vfd_host_end.sv
`timescale 1ns/1ps
module vfd_word_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  input  wire logic             clock,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0]   count;
    logic          full;
  } fifo_state_s;

  fifo_state_s      cur;
  fifo_state_s      next_cur;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             pop;

  assign push = in_valid & ~cur.full;
  assign pop  = out_ready & (cur.count != '0);

  always_comb begin
    next_cur = cur;
    if (push) begin
      next_cur.wr_ptr = cur.wr_ptr + 1'b1;
    end
    if (pop) begin
      next_cur.rd_ptr = cur.rd_ptr + 1'b1;
    end
    if (push & ~pop) begin
      next_cur.count = cur.count + 1'b1;
    end else if (pop & ~push) begin
      next_cur.count = cur.count - 1'b1;
    end
    next_cur.full = (next_cur.count == (AW+1)'(DEPTH));
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  always_ff @(posedge clock) begin
    if (push) begin
      mem[cur.wr_ptr] <= in_data;
    end
  end

  assign in_ready  = ~cur.full;
  assign out_valid = (cur.count != '0);
  assign out_data  = mem[cur.rd_ptr];

endmodule // vfd_word_fifo

module vfd_host_end (
  input  wire logic                         clock,
  input  wire logic                         resetn,
  input  wire logic [vfd_pkg::WORD_BITS-1:0] word_data,
  input  wire logic                         word_valid,
  output logic                              word_ready,
  input  wire logic                         blank_request,
  output logic                              busy,
  vfd_link.host                             link
);
  typedef struct packed {
    vfd_pkg::host_state_e              state;
    logic [vfd_pkg::COUNT_W-1:0]       count;
    logic [3:0]                        bits_left;
    logic [vfd_pkg::WORD_BITS-1:0]     word;
    logic                              serial_clock;
    logic                              serial_in;
    logic                              load;
    logic                              blank;
    logic                              busy;
  } host_state_s;

  host_state_s                   cur;
  host_state_s                   next_cur;
  logic [vfd_pkg::WORD_BITS-1:0] fifo_data;
  logic                          fifo_valid;
  logic                          take;
  logic                          fifo_ready;

  assign take = (cur.state == vfd_pkg::host_idle) & fifo_valid;

  vfd_word_fifo #(
    .WIDTH (vfd_pkg::WORD_BITS),
    .DEPTH (vfd_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .resetn    (resetn),
    .in_data   (word_data),
    .in_valid  (word_valid),
    .in_ready  (fifo_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (take)
  );

  always_comb begin
    next_cur = cur;
    next_cur.blank = blank_request;
    if (cur.count != '0) begin
      next_cur.count = cur.count - 1'b1;
    end
    case (cur.state)
      vfd_pkg::host_idle: begin
        next_cur.serial_clock = 1'b0;
        next_cur.busy = fifo_valid;
        if (fifo_valid) begin
          next_cur.word = fifo_data;
          next_cur.bits_left = 4'(vfd_pkg::WORD_BITS);
          next_cur.state = vfd_pkg::host_clk_low;
          next_cur.count = vfd_pkg::SCLK_HALF_CYCLES;
        end
      end
      vfd_pkg::host_clk_low: begin
        // data is set up a full half period before the rise
        next_cur.serial_clock = 1'b0;
        next_cur.serial_in = cur.word[vfd_pkg::WORD_BITS-1];
        if (cur.count == '0) begin
          next_cur.serial_clock = 1'b1;
          next_cur.state = vfd_pkg::host_clk_high;
          next_cur.count = vfd_pkg::SCLK_HALF_CYCLES;
          next_cur.bits_left = cur.bits_left - 1'b1;
          next_cur.word = {cur.word[vfd_pkg::WORD_BITS-2:0], 1'b0};
        end
      end
      vfd_pkg::host_clk_high: begin
        if (cur.count == '0) begin
          next_cur.serial_clock = 1'b0;
          next_cur.count = vfd_pkg::SCLK_HALF_CYCLES;
          if (cur.bits_left == '0) begin
            next_cur.state = vfd_pkg::host_load_wait;
            next_cur.count = vfd_pkg::LOAD_HOLD_CYCLES;
          end else begin
            next_cur.state = vfd_pkg::host_clk_low;
          end
        end
      end
      vfd_pkg::host_load_wait: begin
        if (cur.count == '0) begin
          next_cur.load = 1'b1;
          next_cur.state = vfd_pkg::host_load_high;
          next_cur.count = vfd_pkg::LOAD_HIGH_CYCLES;
        end
      end
      vfd_pkg::host_load_high: begin
        if (cur.count == '0) begin
          next_cur.load = 1'b0;
          next_cur.state = vfd_pkg::host_idle;
          next_cur.busy = 1'b0;
        end
      end
      default: begin
        next_cur.state = vfd_pkg::host_idle;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign word_ready        = fifo_ready;
  assign busy              = cur.busy;
  assign link.serial_clock = cur.serial_clock;
  assign link.serial_in    = cur.serial_in;
  assign link.load         = cur.load;
  assign link.blank        = cur.blank;

endmodule // vfd_host_end

// ### dv/vfd_link_checker.sv
`timescale 1ns/1ps
module vfd_link_checker (
  input wire logic                          clock,
  input wire logic                          resetn,
  input wire logic                          serial_clock,
  input wire logic                          serial_in,
  input wire logic                          load,
  input wire logic                          blank,
  input wire logic                          serial_out,
  input wire logic [vfd_pkg::WORD_BITS-1:0] driver_outputs
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  chk_reset_clears: assert property (disable iff (1'b0)
    !resetn |=> !serial_out && driver_outputs == '0 && !load)
    else $error("state not cleared by reset");
  chk_clk_high_time: assert property ($rose(serial_clock) |->
    ##10 serial_clock ##1 !serial_clock) else $error("clock high time");
  chk_din_stable: assert property ($rose(serial_clock) |->
    $stable(serial_in) ##1 $stable(serial_in)) else $error("data moved");
  chk_load_idle: assert property (serial_clock |-> !load)
    else $error("load high while shifting");
  chk_load_width: assert property ($rose(load) |->
    load[*7] ##1 !load) else $error("load pulse width");
  chk_blank_zero: assert property (blank[*5] |->
    driver_outputs == '0) else $error("outputs not blanked");
  chk_sout_fall: assert property ($changed(serial_out) |->
    !serial_clock && !$past(serial_clock, 2))
    else $error("serial out moved off clock fall");
  chk_latch_hold: assert property ((!load && !blank)[*8] |->
    $stable(driver_outputs)) else $error("latch not held");
  cover property ($fell(load));
  cover property (blank[*5]);
  cover property ($changed(serial_out));
endmodule // vfd_link_checker

// ### dv/vfd_serial_shift_latch_driver_bench.sv
`timescale 1ns/1ps
module vfd_serial_shift_latch_driver_bench;
  localparam int W = vfd_pkg::WORD_BITS;
  logic         clock;
  logic         resetn;
  logic [W-1:0] word_data;
  logic         word_valid;
  logic         word_ready;
  logic         blank_request;
  logic         busy;
  logic [W-1:0] out_a;
  logic [W-1:0] out_b;
  logic [W-1:0] cap;
  logic [W-1:0] sr;
  logic [W-1:0] lat;
  logic [W-1:0] w;
  int           bad_count;
  int           n_compared;
  int           cycles;
  int           n;
  vfd_link link_a ();
  vfd_link link_b ();
  vfd_host_end u_vfd_host_end (.clock(clock), .resetn(resetn),
    .word_data(word_data), .word_valid(word_valid), .word_ready(word_ready),
    .blank_request(blank_request), .busy(busy), .link(link_a));
  vfd_driver_end u_vfd_driver_end (.clock(clock), .resetn(resetn),
    .link(link_a), .driver_outputs(out_a));
  vfd_driver_end u_vfd_driver_end_b (.clock(clock), .resetn(resetn),
    .link(link_b), .driver_outputs(out_b));
  vfd_link_checker u_vfd_link_checker (.clock(clock), .resetn(resetn),
    .serial_clock(link_a.serial_clock), .serial_in(link_a.serial_in),
    .load(link_a.load), .blank(link_a.blank),
    .serial_out(link_a.serial_out), .driver_outputs(out_a));

  initial begin
    clock = 0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      report_and_stop();
    end
  end
  // wire order as seen at each link clock rise
  always @(posedge link_a.serial_clock) cap <= {cap[W-2:0], link_a.serial_in};

  task automatic tick(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask
  task automatic check(input logic [W-1:0] seen, input logic [W-1:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wait_idle();
    int quiet;
    quiet = 0;
    for (int i = 0; i < 9000 && quiet < 40; i++) begin
      tick(1);
      quiet = busy ? 0 : quiet + 1;
    end
  endtask
  task automatic send(input logic [W-1:0] v);
    word_data = v;
    word_valid = 1;
    while (!word_ready) tick(1);
    tick(1);
    word_valid = 0;
    tick(2);
    check(W'(busy), 12'h001);
    wait_idle();
  endtask
  // bench stands in for a host on the second link, 160 ns clock
  task automatic shift_b(input logic b);
    link_b.serial_clock = 0;
    link_b.serial_in = b;
    tick(8);
    check(W'(link_b.serial_out), W'(sr[W-1]));
    check(out_b, link_b.blank ? '0 : lat);
    link_b.serial_clock = 1;
    sr = {sr[W-2:0], b};
    if (link_b.load) lat = sr;
    tick(8);
  endtask
  task automatic report_and_stop();
    if (bad_count == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    {resetn, word_valid, word_data, blank_request, cap, sr, lat} = '0;
    {link_b.serial_clock, link_b.serial_in, link_b.load, link_b.blank} = '0;
    {bad_count, n_compared, cycles} = '0;
    tick(3);
    resetn = 1;
    tick(4);
    check(out_a, '0);
    check(W'(link_a.serial_out), '0);
    for (int i = 0; i < 4; i++) begin
      w = (i == 0) ? 12'h801 : (i == 1) ? 12'h7FE : (i == 2) ? 12'hFFF : '0;
      send(w);
      check(out_a, w);
      check(cap, w);
      check(W'(link_a.serial_out), W'(w[W-1]));
    end
    blank_request = 1;
    tick(6);
    check(out_a, '0);
    send(12'h5A3);
    check(out_a, '0);
    blank_request = 0;
    tick(6);
    check(out_a, 12'h5A3);
    n = 0;
    word_valid = 1;
    while (word_ready && n < 20) begin
      word_data = W'(12'h100 + n);
      tick(1);
      n++;
    end
    word_data = 12'hEEE;
    tick(2);
    word_valid = 0;
    check(W'(n), W'(vfd_pkg::FIFO_DEPTH + 1));
    wait_idle();
    check(out_a, W'(12'h100 + n - 1));
    link_b.load = 1;
    w = 12'hA5C;
    for (int i = W - 1; i >= 0; i--) shift_b(w[i]);
    link_b.load = 0;
    link_b.blank = 1;
    w = 12'h3F0;
    for (int i = W - 1; i >= 0; i--) shift_b(w[i]);
    link_b.blank = 0;
    tick(8);
    check(out_b, 12'hA5C);
    link_b.load = 1;
    tick(8);
    link_b.load = 0;
    tick(8);
    check(out_b, 12'h3F0);
    resetn = 0;
    tick(3);
    check(out_a, '0);
    check(out_b, '0);
    resetn = 1;
    tick(2);
    report_and_stop();
  end
endmodule // vfd_serial_shift_latch_driver_bench
